/* twc_params.svh */
/*
 * register offsets, field positions, reset values and mode codes for the
 * timer waveform control block.
 * assumes: included by bare name from the package and the design module.
 */
`ifndef TWC_PARAMS_SVH
`define TWC_PARAMS_SVH

// ----------------------------------------------------------------------
// register word indices; the byte address is four times the index
// ----------------------------------------------------------------------
`define TWC_IDX_MODE_CTRL    8'h01
`define TWC_IDX_SPLIT_CTRL   8'h02
`define TWC_IDX_LOCK_CTRL    8'h03
`define TWC_IDX_STATUS       8'h04
`define TWC_IDX_TIMER_CTRL   8'h05
`define TWC_IDX_PERIOD       8'h06
`define TWC_IDX_CMP_BASE     8'h08
`define TWC_ADDR_W           12

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TWC_MODE_LSB         0
`define TWC_AUTO_LOCK_BIT    3
`define TWC_EN_LSB           4
`define TWC_LOW_LSB          0
`define TWC_HIGH_LSB         4
`define TWC_LOCK_BIT         0
`define TWC_RUN_BIT          0
`define TWC_SPLIT_BIT        1

// ----------------------------------------------------------------------
// reset values and mode codes
// ----------------------------------------------------------------------
`define TWC_RST_BYTE         8'h00
`define TWC_RST_WORD         16'h0000
`define TWC_MODE_MASK        8'h7f
`define TWC_SPLIT_MASK       8'h77
`define TWC_MODE_NORMAL      3'h0
`define TWC_MODE_FREQ        3'h1
`define TWC_MODE_RESERVED    3'h2
`define TWC_MODE_SINGLE      3'h3
`define TWC_CHANNELS         3

`endif

/* twc_pkg.sv */
/*
 * types shared by the timer waveform control block.
 * assumes: twc_params.svh is on the include path.
 */
`include "twc_params.svh"

package twc_pkg;

    typedef enum logic [2:0]
    {
        TWC_NORMAL   = 3'h0,
        TWC_FREQ     = 3'h1,
        TWC_RESERVED = 3'h2,
        TWC_SINGLE   = 3'h3
    } twc_mode_t;

    typedef struct packed
    {
        logic       unused;
        logic [2:0] channel_output_enable;
        logic       automatic_lock_update;
        logic [2:0] generation_mode;
    } twc_mode_reg_t;

    typedef struct packed
    {
        logic [2:0] wave;
        logic [2:0] oe;
    } twc_pins_t;

endpackage

/* twc_core.sv */
/*
 * timer waveform control: a 16-bit counter with three compare channels,
 * buffered compare updates with automatic lock, generation modes and
 * pin override, reached over APB.
 * assumes: APB master on I_CLK; port direction set outside this block.
 */
// The APB slave port was left to the implementer.
// What this block does
// R1 - enabled channel overrides port output in generation modes
// R2 - enable zero keeps port value, one overrides
// R3 - auto lock holds lock until enabled buffers valid
// R4 - lock stays clear until update, then copy, set
// R5 - without auto lock only software changes lock
// R6 - normal mode drives no waveform output
// R7 - waveform reaches pin only when enable set
// R8 - software sets pin direction as output; this block leaves pin direction to the port
// R9 - mode 000 normal, period top, events at top
// R10 - mode 001 frequency, channel zero top; 010 reserved
// R11 - mode 011 single slope, events at bottom
// R12 - mode field sets count, top, update, waveform
// R13 - split mode output values settable while stopped
// R14 - high outputs bits 6:4, low outputs 2:0
// R15 - reserved mode behaves as normal mode
`timescale 1ns/100ps

`include "twc_params.svh"

module twc_core
    import twc_pkg::*;
#(
    parameter int CW = 16
)
(
    input  wire logic                    I_CLK,
    input  wire logic                    I_RESET,
    input  wire logic                    I_PSEL,
    input  wire logic                    I_PENABLE,
    input  wire logic                    I_PWRITE,
    input  wire logic [`TWC_ADDR_W-1:0]  I_PADDR,
    input  wire logic [31:0]             I_PWDATA,
    input  wire logic [2:0]              I_PORT_OUT,
    output logic [31:0]                  O_PRDATA,
    output logic                         O_PREADY,
    output logic                         O_PSLVERR,
    output logic [2:0]                   O_WAVE_PIN,
    output logic [2:0]                   O_OVERRIDE
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    twc_mode_reg_t mode_reg;
    logic [7:0]    split_reg;
    logic          update_lock;
    logic          run;
    logic          split;
    logic [CW-1:0] period;
    logic [CW-1:0] count;
    logic [CW-1:0] cmp      [`TWC_CHANNELS];
    logic [CW-1:0] cmp_buf  [`TWC_CHANNELS];
    logic [2:0]    buf_valid;
    logic [2:0]    wave;
    logic          ovf_flag;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire           access   = I_PSEL & I_PENABLE;
    wire           wr       = access & I_PWRITE;
    wire [9:0]     idx      = I_PADDR[`TWC_ADDR_W-1:2];
    wire           sel_mode = idx == 10'(`TWC_IDX_MODE_CTRL);
    wire           sel_spl  = idx == 10'(`TWC_IDX_SPLIT_CTRL);
    wire           sel_lock = idx == 10'(`TWC_IDX_LOCK_CTRL);
    wire           sel_stat = idx == 10'(`TWC_IDX_STATUS);
    wire           sel_tmr  = idx == 10'(`TWC_IDX_TIMER_CTRL);
    wire           sel_per  = idx == 10'(`TWC_IDX_PERIOD);
    wire [9:0]     cmp_off  = idx - 10'(`TWC_IDX_CMP_BASE);
    wire           sel_cmp  = idx >= 10'(`TWC_IDX_CMP_BASE) && cmp_off < 10'(`TWC_CHANNELS);
    wire           mapped   = sel_mode | sel_spl | sel_lock | sel_stat | sel_tmr
                              | sel_per | sel_cmp;
    wire [1:0]     cmp_sel  = cmp_off[1:0];

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    twc_mode_t     mode;
    assign mode = twc_mode_t'(mode_reg.generation_mode);
    wire           is_freq   = mode == TWC_FREQ;                                    // R10
    wire           is_single = mode == TWC_SINGLE;                                  // R11
    wire           generating = is_freq | is_single;                                // R6 R15
    wire [CW-1:0]  top       = is_freq ? cmp[0] : period;                           // R9 R10 R12
    wire           at_top    = count == top;
    wire           at_bottom = count == '0;
    // single slope rolls over at top, so the bottom event is the wrap into zero
    wire           wrap      = run & at_top;
    wire           update_ev = run & (is_single ? at_bottom : at_top);              // R9 R11 R12
    wire [2:0]     enabled   = mode_reg.channel_output_enable;
    wire           all_valid = (buf_valid & enabled) == enabled;
    wire           lock_wr   = wr & sel_lock;
    wire           mode_wr   = wr & sel_mode;
    wire           stat_rd   = access & ~I_PWRITE & sel_stat;
    wire           copy_ok   = update_ev & ~update_lock;

    // ------------------------------------------------------------------
    // lock control
    // ------------------------------------------------------------------
    logic next_update_lock;
    always_comb
    begin
        next_update_lock = update_lock;
        if (lock_wr)
        begin
            next_update_lock = I_PWDATA[`TWC_LOCK_BIT];                             // R5
        end
        else if (mode_wr && I_PWDATA[`TWC_AUTO_LOCK_BIT])
        begin
            // arming auto lock closes the gate until every enabled buffer is fresh
            next_update_lock = 1'b1;                                                // R3
        end
        else if (mode_reg.automatic_lock_update)
        begin
            if (update_lock && all_valid)
            begin
                next_update_lock = 1'b0;                                            // R3
            end
            else if (!update_lock && update_ev)
            begin
                next_update_lock = 1'b1;                                            // R4
            end
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            update_lock <= 1'b0;
        end
        else
        begin
            update_lock <= next_update_lock;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            mode_reg <= twc_mode_reg_t'(`TWC_RST_BYTE);
        end
        else if (mode_wr)
        begin
            // bit 7 is not implemented and reads back as zero
            mode_reg <= twc_mode_reg_t'(I_PWDATA[7:0] & `TWC_MODE_MASK);
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            split_reg <= `TWC_RST_BYTE;
        end
        else if (wr && sel_spl)
        begin
            split_reg <= I_PWDATA[7:0] & `TWC_SPLIT_MASK;                           // R14
        end
    end

    // split only matters while stopped; a running timer owns the levels
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            run   <= 1'b0;
            split <= 1'b0;
        end
        else if (wr && sel_tmr)
        begin
            run   <= I_PWDATA[`TWC_RUN_BIT];
            split <= I_PWDATA[`TWC_SPLIT_BIT];
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            period <= '1;
        end
        else if (wr && sel_per)
        begin
            period <= I_PWDATA[CW-1:0];
        end
    end

    // ------------------------------------------------------------------
    // counter and compare channels
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            count <= '0;
        end
        else if (run)
        begin
            count <= wrap ? '0 : count + 1'b1;
        end
    end

    // overflow sticks until status is read; a new overflow wins
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            ovf_flag <= 1'b0;
        end
        else if (update_ev)
        begin
            ovf_flag <= 1'b1;                                                       // R12
        end
        else if (stat_rd)
        begin
            ovf_flag <= 1'b0;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < `TWC_CHANNELS; ch = ch + 1)
        begin : g_ch
            wire buf_wr = wr & sel_cmp & (cmp_sel == 2'(ch));
            wire hi_val = split_reg[`TWC_HIGH_LSB + ch];
            always_ff @(posedge I_CLK or posedge I_RESET)
            begin
                if (I_RESET)
                begin
                    cmp[ch]       <= `TWC_RST_WORD;
                    cmp_buf[ch]   <= `TWC_RST_WORD;
                    buf_valid[ch] <= 1'b0;
                    wave[ch]      <= 1'b0;
                end
                else
                begin
                    if (buf_wr)
                    begin
                        cmp_buf[ch]   <= I_PWDATA[CW-1:0];
                        buf_valid[ch] <= 1'b1;
                    end
                    // a buffer write in an update cycle wins; that channel copies later
                    else if (copy_ok)
                    begin
                        cmp[ch]       <= cmp_buf[ch];                               // R4
                        buf_valid[ch] <= 1'b0;
                    end
                    if (!run && split)
                    begin
                        // split mode, stopped: software drives the level
                        wave[ch] <= split_reg[`TWC_LOW_LSB + ch] | hi_val;          // R13
                    end
                    else if (run && is_freq && at_top)
                    begin
                        wave[ch] <= ~wave[ch];                                      // R10
                    end
                    else if (run && is_single)
                    begin
                        wave[ch] <= (wrap ? '0 : count + 1'b1) < cmp[ch];           // R11
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    // pin direction stays with the port; the override only picks the level source
    wire [2:0] ovr      = generating ? enabled : 3'h0;                              // R1 R6 R7 R15
    wire [2:0] next_pin = (ovr & wave) | (~ovr & I_PORT_OUT);                       // R2

    // ------------------------------------------------------------------
    // read mux and outputs
    // ------------------------------------------------------------------
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0;
        if (sel_mode)
        begin
            next_rdata = {24'h0, mode_reg};
        end
        else if (sel_spl)
        begin
            next_rdata = {24'h0, split_reg};
        end
        else if (sel_lock)
        begin
            next_rdata = {31'h0, update_lock};
        end
        else if (sel_stat)
        begin
            // read data is taken at setup, before the access clears the flag
            next_rdata = {27'h0, ovf_flag, buf_valid, 1'b0};
        end
        else if (sel_tmr)
        begin
            next_rdata = {30'h0, split, run};
        end
        else if (sel_per)
        begin
            next_rdata = {16'h0, period};
        end
        else if (sel_cmp)
        begin
            next_rdata = {16'h0, cmp[cmp_sel]};
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            O_PRDATA   <= 32'h0;
            O_PREADY   <= 1'b0;
            O_PSLVERR  <= 1'b0;
            O_WAVE_PIN <= 3'h0;
            O_OVERRIDE <= 3'h0;
        end
        else
        begin
            // every setup cycle is answered, so back-to-back transfers never stall
            O_PREADY   <= I_PSEL & ~I_PENABLE;
            O_PSLVERR  <= I_PSEL & ~I_PENABLE & ~mapped;
            O_PRDATA   <= next_rdata;
            O_WAVE_PIN <= next_pin;
            O_OVERRIDE <= ovr;
        end
    end

endmodule

/* twc_port_model.sv */
/* port partner: output register and direction of the three waveform pins.
   assumes its set input changes just after bench clock edges. */
`timescale 1ns/100ps
module twc_port_model
(
    input  wire logic       i_clk,
    input  wire logic [2:0] i_set,
    input  wire logic [2:0] i_pin,
    output logic      [2:0] o_port,
    output logic      [2:0] o_seen
);
    // all pins are outputs, else no waveform shows on them
    localparam logic [2:0] DIR = 3'h7;
    initial o_port = 3'h0;
    always @(posedge i_clk)
        o_port <= i_set;
    // an input pin reads inverted so a floating level never matches
    assign o_seen = (i_pin & DIR) | (~o_port & ~DIR);
endmodule

/* twc_core_sva.sv */
/* checker for the twc_core ports, bound below.
   assumes a write lands where psel, penable and pready are high. */
`timescale 1ns/100ps
`include "twc_params.svh"
module twc_core_sva
    import twc_pkg::*;
(
    input wire logic                   I_CLK,
    input wire logic                   I_RESET,
    input wire logic                   I_PSEL,
    input wire logic                   I_PENABLE,
    input wire logic                   I_PWRITE,
    input wire logic [`TWC_ADDR_W-1:0] I_PADDR,
    input wire logic [31:0]            I_PWDATA,
    input wire logic [2:0]             I_PORT_OUT,
    input wire logic [31:0]            O_PRDATA,
    input wire logic                   O_PREADY,
    input wire logic                   O_PSLVERR,
    input wire logic [2:0]             O_WAVE_PIN,
    input wire logic [2:0]             O_OVERRIDE
);
    // ----
    // shadows of software writes
    // ----
    wire [9:0]  idx  = I_PADDR[11:2];
    wire        done = I_PSEL && I_PENABLE && O_PREADY;
    wire        wr   = done && I_PWRITE;
    wire        rd   = done && !I_PWRITE;
    wire        map  = idx inside {[1:6], [8:10]};
    logic [7:0] mode_q, mode_d, split_q;
    logic [1:0] up;
    logic       lock_q, lock_ok;
    // the registered override trails a mode write, so wait one still edge
    wire        calm = up == 2'h3 && mode_q == mode_d;
    always_ff @(posedge I_CLK or posedge I_RESET)
        if (I_RESET)
        begin
            {mode_q, mode_d, split_q, lock_q, up} <= '0;
            lock_ok <= 1'b1;
        end
        else
        begin
            mode_d <= mode_q;
            up <= up + {1'b0, up != 2'h3};
            if (wr && idx == 10'h1) mode_q <= I_PWDATA[7:0] & 8'h7f;
            if (wr && idx == 10'h2) split_q <= I_PWDATA[7:0] & 8'h77;
            if (wr && idx == 10'h3) lock_q <= I_PWDATA[0];
            // auto lock hands the bit to hardware until software writes it
            if (wr && (idx == 10'h3 || (idx == 10'h1 && I_PWDATA[3]))) lock_ok <= idx == 10'h3;
        end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    sequence s_setup; I_PSEL && !I_PENABLE; endsequence
    sequence s_pulse; O_PREADY ##1 !O_PREADY; endsequence
    property p_ready; s_setup |=> s_pulse; endproperty
    a_ready: assert property (p_ready) else $error("ready not a pulse");
    property p_unmap; done && !map |-> O_PSLVERR && (I_PWRITE || O_PRDATA == 32'h0); endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_quiet; calm && mode_q[2:0] inside {3'h0, 3'h2} |-> O_OVERRIDE == 3'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("override without waveform mode");
    property p_enable; calm && mode_q[2:0] inside {3'h1, 3'h3} |-> O_OVERRIDE == mode_q[6:4]; endproperty
    a_enable: assert property (p_enable) else $error("override not enables");
    property p_port; calm && O_OVERRIDE == 3'h0 |-> O_WAVE_PIN == $past(I_PORT_OUT); endproperty
    a_port: assert property (p_port) else $error("pin not port value");
    property p_split; rd && idx == 10'h2 |-> O_PRDATA == {24'h0, split_q}; endproperty
    a_split: assert property (p_split) else $error("split value readback");
    property p_mode; rd && idx == 10'h1 |-> O_PRDATA == {24'h0, mode_q}; endproperty
    a_mode: assert property (p_mode) else $error("mode readback");
    property p_lock; rd && idx == 10'h3 && !mode_q[3] && lock_ok |-> O_PRDATA[0] == lock_q; endproperty
    a_lock: assert property (p_lock) else $error("lock changed by hardware");
endmodule
bind twc_core twc_core_sva twc_core_sva_i (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .I_PORT_OUT(I_PORT_OUT), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_WAVE_PIN(O_WAVE_PIN), .O_OVERRIDE(O_OVERRIDE));

/* twc_core_tb_top.sv */
/* self-checking bench for twc_core: apb master, register model, port partner.
   assumes the package, the checker and the partner are compiled first. */
`timescale 1ns/100ps
module twc_core_tb_top
    import twc_pkg::*;
;
    logic          clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0]   paddr = 12'h000;
    logic [31:0]   pwdata = 32'h0, prdata, rd, v;
    logic [2:0]    port_set = 3'h0, port_out, wpin, ovr, seen, eo;
    logic          pready, pslverr, er;
    logic [7:0]    rm [0:15];
    twc_mode_reg_t mw;
    int            n_errors = 0, checked = 0, seed = 53445;
    twc_core twc_core_i (.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PORT_OUT(port_out),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_WAVE_PIN(wpin),
        .O_OVERRIDE(ovr));
    twc_port_model twc_port_model_i (.i_clk(clk), .i_set(port_set), .i_pin(wpin),
        .o_port(port_out), .o_seen(seen));
    initial
        forever #4 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one idle edge after each transfer keeps psel from two drives in one step
    task automatic apb(input logic w, input int idx, input logic [31:0] wd);
        psel <= 1'b1;
        pwr <= w;
        paddr <= 12'(idx * 4);
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input int idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d});
        rm[idx] = d & (idx == 2 ? 8'h77 : 8'h7f);
        chk(32'(er), 32'h0);
    endtask
    task automatic rc(input int idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h0);
        chk(rd, e);
    endtask
    task automatic stop_test();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        rm = '{default: 8'h00};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rc(1, 32'h0);
        rc(2, 32'h0);
        for (int k = 0; k < 8; k++)
        begin
            v = $random(seed);
            mw = '{v[7], v[6:4], 1'b0, 3'(k % 4)};
            wr(1, mw);
            port_set <= v[10:8];
            repeat (4) @(posedge clk);
            eo = mw.generation_mode inside {TWC_FREQ, TWC_SINGLE} ? mw[6:4] : 3'h0;
            chk(32'(ovr), 32'(eo));
            chk(32'(seen & ~eo), 32'(v[10:8] & ~eo));
            rc(1, 32'(rm[1]));
        end
        wr(5, 8'h02);
        wr(1, 8'h73);
        for (int k = 0; k < 4; k++)
        begin
            v = $random(seed);
            wr(2, v[7:0]);
            repeat (3) @(posedge clk);
            chk(32'(seen), 32'(v[6:4] | v[2:0]));
            rc(2, 32'(rm[2]));
        end
        apb(1'b1, 7, 32'hffff_ffff);
        chk(32'(er), 32'h1);
        apb(1'b0, 7, 32'h0);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        wr(5, 8'h00);
        wr(1, 8'h03);
        wr(3, 8'h01);
        rc(3, 32'h1);
        wr(3, 8'h00);
        wr(6, 8'h04);
        wr(5, 8'h01);
        repeat (20) @(posedge clk);
        rc(3, 32'h0);
        wr(5, 8'h00);
        wr(1, 8'h3b);
        rc(3, 32'h1);
        wr(8, 8'h05);
        rc(3, 32'h1);
        wr(9, 8'h06);
        rc(3, 32'h0);
        rc(8, 32'h0);
        wr(5, 8'h01);
        repeat (20) @(posedge clk);
        rc(3, 32'h1);
        rc(8, 32'h5);
        rc(9, 32'h6);
        // frequency mode, channel 0 only; lock stays set so compare 0 holds 5
        wr(1, 8'h11);
        repeat (8) @(posedge clk);
        eo = seen;
        while (seen === eo)
            @(posedge clk);
        eo = seen;
        // top is compare 0 = 5, so the level toggles every 6 edges
        repeat (5) @(posedge clk);
        chk(32'(seen), 32'(eo));
        @(posedge clk);
        chk(32'(seen), 32'(eo ^ 3'h1));
        rc(3, 32'h1);
        rc(4, 32'h10);
        stop_test();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        stop_test();
    end
endmodule
